// ===== rtl/eeprom_page_access_unit.sv
// Notes on behaviour
// [RULE1] Pointer steps after reads and write or erase/write cycles, not after erase.
// [RULE2] Pointer wraps to zero past its top count.
// [RULE3] Pointer top bit always reads zero; seven bits carry the address.
// [RULE4] Bits six to two pick the page; low bits ignored in page cycles.
// [RULE5] Reads use the low two bits as byte within the page.
// [RULE6] Latch loads use the low two bits to pick the latch.
// [RULE7] Increment mode steps the latch subcounter, stopping at latch three.
// [RULE8] Data port read returns the addressed array byte at once.
// [RULE9] Data port write fills a latch and leaves the array alone.
// [RULE10] Loading a latch sets its byte-select flag.
// [RULE11] Latches are write only and accumulate bits by OR.
// [RULE12] Every array cycle ends by clearing all latches and flags.
// [RULE13] Software never touches the factory test register.
// [RULE14] Software starts an access only with the in-progress bit clear.
// [RULE15] Software leaves registers alone during a cycle or its setup.
// [RULE16] Software loads the interval reload for 5 ms before timed cycles.
// [RULE17] Cycle end clears in-progress; interrupt only when both enables are set.
// [RULE18] Write and erase take one interval; erase/write takes two.
// [RULE19] Bytes with clear flags stay untouched by page cycles.
// [RULE20] Erase page erases exactly the flagged bytes.
// [RULE21] Write page ORs each flagged latch into its page byte.
// [RULE22] Erase/write erases flagged bytes, then writes the latches into them.
// [RULE23] In-progress bit and three mode bits select the operation; some codes forbidden.
// [RULE24] Setting in-progress launches the timed cycle and the interval timer.
// [RULE25] Final underflow stops timer, sets flag, clears in-progress and mode.
//
// Local design decision: the address-and-strobe port.
`include "nvm_defs.svh"
`default_nettype none

module eeprom_page_access_unit (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_in,
	// Register port
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Interval timer
	output logic timer_load_out,
	output logic timer_run_out,
	input wire logic timer_underflow_in,
	// Interrupt
	input wire logic shared_irq_enable_in,
	output logic interval_irq_out
);

	logic [6:0] nvm_address_pointer;
	logic timer_run;
	logic interval_irq_enable;
	logic interval_underflow_flag;
	logic cycle_in_progress;
	logic [2:0] mode_bits;
	logic [3:0][7:0] write_latches;
	logic [3:0] byte_select_flags;
	nvm_pkg::cycle_state_t state;
	nvm_pkg::cycle_state_t next_state;

	logic wr_addr;
	logic wr_data;
	logic wr_ctrl;
	logic rd_data;
	logic [2:0] new_mode;
	logic new_mode_bad;
	logic new_is_write;
	logic new_is_timed;
	logic launch;
	logic underflow;
	logic cycle_end;
	logic phase_reload;
	logic [1:0] latch_sel;

	// Reset image of the control byte
	localparam logic [7:0] CTRL_INIT = `CTRL_RESET;

	nvm_array_if arr_bus();

	nvm_array #(
		.PAGES(32)
	) u_array (
		.clock_in(clock_in),
		.arr(arr_bus)
	);

	// Register strobes
	always_comb begin
		wr_addr = 1'b0;
		wr_data = 1'b0;
		wr_ctrl = 1'b0;
		if (addr_in == `NVM_ADDR_OFS) begin
			wr_addr = wr_in;
		end else if (addr_in == `NVM_DATA_OFS) begin
			wr_data = wr_in;
		end else if (addr_in == `NVM_CTRL_OFS) begin
			wr_ctrl = wr_in;
		end
	end

	assign rd_data = rd_in && (addr_in == `NVM_DATA_OFS);
	assign latch_sel = nvm_address_pointer[1:0];

	// Mode decode of a control write
	assign new_mode = wdata_in[`CTL_MODE_MSB:`CTL_MODE_LSB];
	assign new_mode_bad = (new_mode == `MODE_BAD_A) || (new_mode == `MODE_BAD_B)
		|| (new_mode == `MODE_BAD_C); // [RULE23]
	assign new_is_write = (new_mode[2:1] == `MODE_WRITE_TOP);
	assign new_is_timed = new_is_write || (new_mode == `MODE_ERASE_WRITE)
		|| (new_mode == `MODE_ERASE); // [RULE23]

	// A timed cycle starts only from idle with a valid code
	assign launch = wr_ctrl && !cycle_in_progress && wdata_in[`CTL_BUSY_BIT]
		&& new_is_timed && !new_mode_bad; // [RULE24] [RULE14]

	assign underflow = timer_underflow_in && (state != nvm_pkg::ST_IDLE);

	// Cycle sequencer
	always_comb begin
		next_state = state;
		case (state)
			nvm_pkg::ST_IDLE: begin
				if (launch) begin
					next_state = new_is_write ? nvm_pkg::ST_WRITE : nvm_pkg::ST_ERASE;
				end
			end
			nvm_pkg::ST_ERASE: begin
				if (underflow) begin
					next_state = (mode_bits == `MODE_ERASE_WRITE) ?
						nvm_pkg::ST_WRITE : nvm_pkg::ST_IDLE; // [RULE18] [RULE22]
				end
			end
			nvm_pkg::ST_WRITE: begin
				if (underflow) begin
					next_state = nvm_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = nvm_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			state <= nvm_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign cycle_end = underflow && (next_state == nvm_pkg::ST_IDLE);

	// Second interval of an erase/write reloads the timer
	assign phase_reload = underflow && (state == nvm_pkg::ST_ERASE)
		&& (next_state == nvm_pkg::ST_WRITE); // [RULE18]
	assign timer_load_out = launch || phase_reload; // [RULE24]
	assign timer_run_out = timer_run;

	// Array commit at the end of each interval
	assign arr_bus.rd_addr = nvm_address_pointer; // [RULE5]
	assign arr_bus.page = nvm_address_pointer[6:2]; // [RULE4]
	assign arr_bus.commit = underflow;
	assign arr_bus.erase = (state == nvm_pkg::ST_ERASE); // [RULE20] [RULE22]
	assign arr_bus.flags = byte_select_flags; // [RULE19]
	assign arr_bus.latches = write_latches; // [RULE21]

	// Control register
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			timer_run <= CTRL_INIT[`CTL_RUN_BIT];
			interval_irq_enable <= CTRL_INIT[`CTL_IRQ_EN_BIT];
			cycle_in_progress <= CTRL_INIT[`CTL_BUSY_BIT];
			mode_bits <= CTRL_INIT[`CTL_MODE_MSB:`CTL_MODE_LSB];
		end else begin
			if (wr_ctrl) begin
				interval_irq_enable <= wdata_in[`CTL_IRQ_EN_BIT];
			end
			if (cycle_end) begin
				timer_run <= 1'b0; // [RULE25]
				cycle_in_progress <= 1'b0; // [RULE17] [RULE25]
				mode_bits <= `MODE_READ; // [RULE25]
			end else if (launch) begin
				timer_run <= 1'b1; // [RULE24]
				cycle_in_progress <= 1'b1; // [RULE24]
				mode_bits <= new_mode;
			end else if (wr_ctrl) begin
				timer_run <= wdata_in[`CTL_RUN_BIT];
				if (!cycle_in_progress && !new_mode_bad) begin
					mode_bits <= new_mode; // [RULE23]
				end
			end
		end
	end

	// Timer flag: underflow wins over a software clear
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			interval_underflow_flag <= CTRL_INIT[`CTL_FLAG_BIT];
		end else if (timer_underflow_in) begin
			interval_underflow_flag <= 1'b1; // [RULE25]
		end else if (wr_ctrl) begin
			interval_underflow_flag <= wdata_in[`CTL_FLAG_BIT];
		end
	end

	assign interval_irq_out = interval_underflow_flag && interval_irq_enable
		&& shared_irq_enable_in; // [RULE17]

	// Address pointer
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			nvm_address_pointer <= `ADDR_RESET;
		end else if (wr_addr) begin
			nvm_address_pointer <= wdata_in[6:0]; // [RULE3]
		end else if (rd_data) begin
			nvm_address_pointer <= nvm_address_pointer + 7'h01; // [RULE1] [RULE2]
		end else if (cycle_end && (mode_bits != `MODE_ERASE)) begin
			nvm_address_pointer <= nvm_address_pointer + 7'h01; // [RULE1] [RULE2]
		end else if (wr_data && (mode_bits == `MODE_INC) && (latch_sel != `LAST_LATCH)) begin
			nvm_address_pointer[1:0] <= latch_sel + 2'h1; // [RULE7]
		end
	end

	// Write latches and byte-select flags
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			write_latches <= '0;
			byte_select_flags <= 4'h0;
		end else if (cycle_end) begin
			write_latches <= '0; // [RULE12]
			byte_select_flags <= 4'h0; // [RULE12]
		end else if (wr_data) begin
			write_latches[latch_sel] <= write_latches[latch_sel] | wdata_in; // [RULE6] [RULE9] [RULE11]
			byte_select_flags[latch_sel] <= 1'b1; // [RULE10]
		end
	end

	// Read data, valid in the cycle after the strobe only
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_out <= `READ_IDLE;
		end else if (rd_in && (addr_in == `NVM_ADDR_OFS)) begin
			rdata_out <= {1'b0, nvm_address_pointer}; // [RULE3]
		end else if (rd_data) begin
			rdata_out <= arr_bus.rd_data; // [RULE8]
		end else if (rd_in && (addr_in == `NVM_CTRL_OFS)) begin
			rdata_out <= {timer_run, interval_irq_enable, interval_underflow_flag,
				cycle_in_progress, mode_bits, 1'b0};
		end else begin
			rdata_out <= `READ_IDLE; // [RULE11]
		end
	end

	// Checks
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	sequence ew_erase_end;
		(state == nvm_pkg::ST_ERASE) && underflow && (mode_bits == `MODE_ERASE_WRITE);
	endsequence

	sequence ew_write_phase;
		(state == nvm_pkg::ST_WRITE) && cycle_in_progress;
	endsequence

	sequence erase_only_end;
		cycle_end && (mode_bits == `MODE_ERASE);
	endsequence

	ptr_msb_read_a: assert property ( // [RULE3]
		rd_in && (addr_in == `NVM_ADDR_OFS) |=> !rdata_out[7])
		else $error("pointer top bit read as one");

	read_step_a: assert property ( // [RULE1]
		rd_data && !wr_in |=> nvm_address_pointer == $past(nvm_address_pointer) + 7'h01)
		else $error("pointer did not step after data read");

	ptr_wrap_a: assert property ( // [RULE2]
		rd_data && (nvm_address_pointer == 7'h7f) |=> nvm_address_pointer == 7'h00)
		else $error("pointer did not wrap to zero");

	erase_hold_a: assert property ( // [RULE1]
		erase_only_end |=> $stable(nvm_address_pointer))
		else $error("pointer moved after erase cycle");

	sub_stop_a: assert property ( // [RULE7]
		wr_data && (mode_bits == `MODE_INC) && (latch_sel == `LAST_LATCH) && !cycle_end
		|=> nvm_address_pointer[1:0] == `LAST_LATCH)
		else $error("latch subcounter passed latch three");

	flag_set_a: assert property ( // [RULE10]
		wr_data && !cycle_end |=> byte_select_flags[$past(latch_sel)])
		else $error("byte-select flag not set by latch load");

	latch_or_a: assert property ( // [RULE11]
		wr_data && !cycle_end |=> write_latches[$past(latch_sel)]
		== ($past(write_latches[latch_sel]) | $past(wdata_in)))
		else $error("latch load did not accumulate by OR");

	end_clear_a: assert property ( // [RULE12]
		cycle_end |=> (byte_select_flags == 4'h0) && (write_latches == '0)
		&& !cycle_in_progress && (mode_bits == `MODE_READ) && !timer_run)
		else $error("cycle end left state behind");

	irq_raise_a: assert property ( // [RULE17]
		cycle_end && interval_irq_enable && shared_irq_enable_in && !wr_ctrl
		|=> interval_irq_out)
		else $error("no interrupt at cycle end");

	ew_second_a: assert property ( // [RULE18]
		ew_erase_end |-> timer_load_out ##1 ew_write_phase)
		else $error("erase/write skipped its write interval");

	launch_start_a: assert property ( // [RULE24]
		launch |-> timer_load_out ##1 (cycle_in_progress && timer_run_out))
		else $error("cycle launch did not start timer");

	read_data_a: assert property ( // [RULE8]
		rd_data |=> rdata_out === $past(arr_bus.rd_data))
		else $error("data port read returned wrong byte");

	bad_mode_a: assert property ( // [RULE23]
		wr_ctrl && new_mode_bad && !cycle_end
		|=> $stable(mode_bits) && $stable(cycle_in_progress))
		else $error("forbidden mode code was taken");

	inc_step_a: assert property ( // [RULE7]
		wr_data && (mode_bits == `MODE_INC) && (latch_sel != `LAST_LATCH) && !cycle_end
		|=> latch_sel == $past(latch_sel) + 2'h1)
		else $error("latch subcounter did not step");

	flag_hw_a: assert property ( // [RULE25]
		timer_underflow_in |=> interval_underflow_flag)
		else $error("underflow did not set the timer flag");

	write_start_a: assert property ( // [RULE21]
		launch && new_is_write
		|=> (state == nvm_pkg::ST_WRITE) && (mode_bits == $past(new_mode)))
		else $error("write page launch did not enter write interval");

	unmapped_read_a: assert property ( // [RULE11]
		rd_in && (addr_in != `NVM_ADDR_OFS) && (addr_in != `NVM_DATA_OFS)
		&& (addr_in != `NVM_CTRL_OFS) |=> rdata_out == `READ_IDLE)
		else $error("unmapped read returned data");

endmodule // eeprom_page_access_unit

`default_nettype wire

// ===== shared/nvm_defs.svh
`ifndef NVM_DEFS_SVH
`define NVM_DEFS_SVH

// Register offsets
`define NVM_ADDR_OFS 8'h01
`define NVM_DATA_OFS 8'h03
`define NVM_CTRL_OFS 8'h04

// Control register field positions
`define CTL_RUN_BIT 7
`define CTL_IRQ_EN_BIT 6
`define CTL_FLAG_BIT 5
`define CTL_BUSY_BIT 4
`define CTL_MODE_MSB 3
`define CTL_MODE_LSB 1

// Mode codes of the three mode bits
`define MODE_READ 3'h0
`define MODE_INC 3'h2
`define MODE_ERASE_WRITE 3'h4
`define MODE_ERASE 3'h7
`define MODE_WRITE_TOP 2'h1
`define MODE_BAD_A 3'h1
`define MODE_BAD_B 3'h5
`define MODE_BAD_C 3'h6

// Reset values
`define ADDR_RESET 7'h00
`define CTRL_RESET 8'h00
`define READ_IDLE 8'h00

// Content of an erased byte
`define ERASED_BYTE 8'h00

// Last latch index
`define LAST_LATCH 2'h3

`endif

// ===== shared/nvm_pkg.sv
`default_nettype none

package nvm_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ERASE = 2'b01,
		ST_WRITE = 2'b10
	} cycle_state_t;

endpackage

`default_nettype wire

// ===== shared/nvm_array_if.sv
`default_nettype none

interface nvm_array_if;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic commit;
	logic erase;
	logic [4:0] page;
	logic [3:0] flags;
	logic [3:0][7:0] latches;

	modport ctrl (
		output rd_addr, commit, erase, page, flags, latches,
		input rd_data
	);

	modport store (
		input rd_addr, commit, erase, page, flags, latches,
		output rd_data
	);
endinterface

`default_nettype wire

// ===== rtl/nvm_array.sv
`include "nvm_defs.svh"
`default_nettype none

module nvm_array #(
	parameter int PAGES = 32
) (
	// Clock
	input wire logic clock_in,
	// Array access
	nvm_array_if.store arr
);

	logic [7:0] lane_rd [4];

	// One storage lane per byte position of a page
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			logic [7:0] lane_mem [PAGES];

			always_ff @(posedge clock_in) begin
				if (arr.commit && arr.flags[g]) begin // [RULE19]
					if (arr.erase) begin
						lane_mem[arr.page] <= `ERASED_BYTE; // [RULE20]
					end else begin
						lane_mem[arr.page] <= lane_mem[arr.page] | arr.latches[g]; // [RULE21]
					end
				end
			end

			assign lane_rd[g] = lane_mem[arr.rd_addr[6:2]];
		end
	endgenerate

	assign arr.rd_data = lane_rd[arr.rd_addr[1:0]]; // [RULE5]

endmodule // nvm_array

`default_nettype wire

// ===== verification/interval_timer_model.sv
`default_nettype none

module interval_timer_model #(
	parameter logic [7:0] RELOAD = 8'h06
) (
	// Clock
	input wire logic clock_in,
	// Control from the access unit
	input wire logic load_in,
	input wire logic run_in,
	// Underflow back to the access unit
	output logic underflow_out
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [7:0] count;

	always_ff @(posedge clock_in) begin
		underflow_out <= 1'b0;
		if (load_in) begin
			count <= RELOAD;
		end else if (run_in && count != 8'h00) begin
			count <= count - 8'h01;
			underflow_out <= (count == 8'h01);
		end
	end
endmodule // interval_timer_model

`default_nettype wire

// ===== verification/tb.sv
`include "nvm_defs.svh"
`default_nettype none

`define CHECK(what, exp, got) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("unexpected %s expected %h seen %h", what, exp, got); \
	end \
end

module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic [7:0] wdata_in = 8'h00;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic shared_irq_enable_in = 1'b0;
	logic [7:0] rdata_out;
	logic timer_load_out;
	logic timer_run_out;
	logic timer_underflow_in;
	logic interval_irq_out;
	logic [7:0] v;
	int miscompares = 0;
	int comparisons = 0;
	int underflows = 0;
	int loads = 0;

	eeprom_page_access_unit dut_u (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata_out),
		.timer_load_out(timer_load_out),
		.timer_run_out(timer_run_out),
		.timer_underflow_in(timer_underflow_in),
		.shared_irq_enable_in(shared_irq_enable_in),
		.interval_irq_out(interval_irq_out)
	);

	interval_timer_model #(.RELOAD(8'h06)) timer_u (
		.clock_in(clock_in),
		.load_in(timer_load_out),
		.run_in(timer_run_out),
		.underflow_out(timer_underflow_in)
	);

	initial begin
		forever #10 clock_in = ~clock_in;
	end

	always @(posedge clock_in) begin
		if (timer_underflow_in === 1'b1)
			underflows++;
		if (timer_load_out === 1'b1)
			loads++;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		// Never aimed at the factory test register
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clock_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask

	task automatic expect_rd(input logic [7:0] a, input logic [7:0] e, input string what);
		rd(a);
		`CHECK(what, e, v)
	endtask

	// Launch, poll the in-progress bit, count interval underflows and loads
	task automatic run_cycle(input logic [7:0] c, input int n);
		int i;
		underflows = 0;
		loads = 0;
		i = 0;
		wr(`NVM_CTRL_OFS, c);
		rd(`NVM_CTRL_OFS);
		`CHECK("control in cycle", c | 8'h80, v)
		`CHECK("timer running", 1'b1, timer_run_out)
		while (v[4] !== 1'b0 && i < 100) begin
			rd(`NVM_CTRL_OFS);
			i++;
		end
		`CHECK("in-progress clear", 1'b0, v[4])
		`CHECK("underflow count", n, underflows)
		`CHECK("timer loads", n, loads)
	endtask

	// Byte 0 of page two in the top byte of e
	task automatic check_page(input logic [31:0] e);
		wr(`NVM_ADDR_OFS, 8'h08);
		for (int k = 0; k < 4; k++) begin
			expect_rd(`NVM_DATA_OFS, e[31 - 8 * k -: 8], "page byte");
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clock_in);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		repeat (10) @(posedge clock_in);
		rst_in <= 1'b0;
		expect_rd(`NVM_ADDR_OFS, 8'h00, "pointer reset");
		expect_rd(`NVM_CTRL_OFS, 8'h00, "control reset");
		expect_rd(8'h02, 8'h00, "unmapped read");
		wr(`NVM_ADDR_OFS, 8'hff);
		expect_rd(`NVM_ADDR_OFS, 8'h7f, "pointer top bit");
		rd(`NVM_DATA_OFS);
		expect_rd(`NVM_ADDR_OFS, 8'h00, "pointer wrap");
		wr(`NVM_CTRL_OFS, 8'h02);
		expect_rd(`NVM_CTRL_OFS, 8'h00, "forbidden mode");
		$display("test pointer done");

		wr(`NVM_CTRL_OFS, 8'h04);
		wr(`NVM_ADDR_OFS, 8'h08);
		wr(`NVM_DATA_OFS, 8'ha1);
		wr(`NVM_DATA_OFS, 8'hb2);
		wr(`NVM_DATA_OFS, 8'hc3);
		wr(`NVM_DATA_OFS, 8'hd4);
		wr(`NVM_DATA_OFS, 8'h08);
		expect_rd(`NVM_ADDR_OFS, 8'h0b, "latch subcounter");
		run_cycle(8'h18, 2);
		expect_rd(`NVM_ADDR_OFS, 8'h0c, "pointer after erase write");
		expect_rd(`NVM_CTRL_OFS, 8'h20, "control after cycle");
		check_page(32'ha1b2c3dc);
		$display("test erase write done");

		wr(`NVM_CTRL_OFS, 8'h00);
		wr(`NVM_ADDR_OFS, 8'h09);
		wr(`NVM_DATA_OFS, 8'h40);
		expect_rd(`NVM_DATA_OFS, 8'hb2, "array before commit");
		wr(`NVM_ADDR_OFS, 8'h0b);
		run_cycle(8'h14, 1);
		expect_rd(`NVM_ADDR_OFS, 8'h0c, "pointer after write");
		check_page(32'ha1f2c3dc);
		$display("test write page done");

		@(posedge clock_in);
		shared_irq_enable_in <= 1'b1;
		wr(`NVM_ADDR_OFS, 8'h0a);
		wr(`NVM_DATA_OFS, 8'h00);
		run_cycle(8'h5e, 1);
		expect_rd(`NVM_ADDR_OFS, 8'h0a, "pointer after erase");
		expect_rd(`NVM_CTRL_OFS, 8'h60, "control after erase");
		`CHECK("irq raised", 1'b1, interval_irq_out)
		@(posedge clock_in);
		shared_irq_enable_in <= 1'b0;
		@(posedge clock_in);
		#1;
		`CHECK("irq shared gate", 1'b0, interval_irq_out)
		check_page(32'ha1f200dc);
		$display("test erase page done");

		// Stale latch content would show in the erased byte
		wr(`NVM_ADDR_OFS, 8'h0a);
		wr(`NVM_DATA_OFS, 8'h01);
		run_cycle(8'h14, 1);
		expect_rd(`NVM_ADDR_OFS, 8'h0b, "pointer after second write");
		check_page(32'ha1f201dc);
		$display("test latch clear done");
		tally_and_finish();
	end
endmodule // tb

`default_nettype wire
